// ---- include/pra_pkg.sv ----
/*
 * constants, register map and types shared by the preset recall / alarm port.
 * assumes a single 250 MHz clock domain and a 32-bit AXI4-Lite register bus.
 */
package pra_pkg;

    // register byte offsets
    localparam logic [7:0] PRA_OFS_CTRL = 8'h00;
    localparam logic [7:0] PRA_OFS_ALARM = 8'h04;
    localparam logic [7:0] PRA_OFS_PRESET = 8'h08;
    localparam logic [7:0] PRA_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] PRA_OFS_IRQ_MASK = 8'h10;

    // control fields
    localparam int PRA_CTRL_MODE_BIT = 0;
    localparam int PRA_CTRL_ALEN_BIT = 1;
    localparam int PRA_CTRL_ARST_BIT = 2;
    localparam int PRA_CTRL_VIEW_BIT = 3;
    localparam logic PRA_CTRL_MODE_RST = 1'b0;
    localparam logic PRA_CTRL_ALEN_RST = 1'b0;

    // alarm and preset register fields
    localparam int PRA_ALARM_SNAP_LSB = 4;
    localparam int PRA_PRESET_BUSY_BIT = 8;

    // interrupt fields
    localparam int PRA_IRQ_RECALL_BIT = 0;
    localparam int PRA_IRQ_ALARM_BIT = 1;
    localparam logic [1:0] PRA_IRQ_MASK_RST = 2'h0;

    // alarm status codes
    localparam logic [2:0] PRA_ALM_NONE = 3'h0;
    localparam logic [2:0] PRA_ALM_NEAR = 3'h1;
    localparam logic [2:0] PRA_ALM_UNLOCK = 3'h2;
    localparam logic [2:0] PRA_ALM_NO_REF = 3'h3;
    localparam logic [2:0] PRA_ALM_FAN = 3'h4;

    // preset selection
    localparam logic [2:0] PRA_SEL_IDLE = 3'h0;

    // timing
    localparam int PRA_CLK_FREQ_MHZ = 250;
    localparam int PRA_RECALL_DELAY_MS = 500;
    localparam int PRA_RECALL_CYCLES = PRA_RECALL_DELAY_MS * 1000 * PRA_CLK_FREQ_MHZ;

    // bus responses
    localparam logic [1:0] PRA_RESP_OKAY = 2'h0;
    localparam logic [1:0] PRA_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic fan_stop;
        logic no_ref;
        logic unlock;
        logic near_unlock;
    } pra_fault_t;

    typedef enum logic {
        PRA_RC_IDLE,
        PRA_RC_WAIT
    } pra_rc_state_t;

endpackage

// ---- core/pra_port.sv ----
/*
 * preset recall and alarm contact port with an AXI4-Lite register file.
 * assumes fault inputs come from logic on aclk; contact pins are asynchronous
 * and pulled high outside; the alarm pin is open drain, resolved outside.
 */
// Overview of operation
// - port works only in contact mode; network access is blocked meanwhile.
// - three lines give preset number, low is one, first line is msb.
// - inputs active low; a high-to-low change of selection triggers recall.
// - recalled preset is applied about half a second after recognition.
// - fan stop, missing, unlocked or drifting reference raise an alarm.
// - alarm line idles high and goes low while an alarm is present.
// - alarm line enable setting; when disabled the line stays inactive.
// - alarm status stays latched after its cause goes away until reset.
// - alarm reset clears status; a still present cause sets it again.
// - status reported as none, near unlock, unlock, no reference, fan.
// - status snapshot taken when the view opens, refreshed on reopening.
`timescale 1ns/1ps

module pra_port
    import pra_pkg::*;
#(
    parameter int RECALL_CYCLES_P = PRA_RECALL_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // contact pins
    input wire logic [2:0] contact_sel_n,
    output logic alarm_line_o,
    output logic alarm_line_oe,
    // instrument side
    input wire pra_fault_t fault_i,
    output logic net_enable,
    output logic recall_stb,
    output logic [2:0] recall_num,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus channel state
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_full_r, w_full_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    // software settings
    logic remote_contact_port_r;
    logic alarm_line_enable_r;
    logic view_open_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_stat_r;

    // alarm and recall state
    pra_fault_t alarm_lat_r;
    logic [2:0] snap_r;
    logic [2:0] sel_m1_r, sel_m2_r, sel_m3_r;
    logic [2:0] sel_stable_r;
    logic [2:0] pend_num_r;
    logic [31:0] dly_cnt_r;
    pra_rc_state_t rc_state_r;
    logic recall_stb_r;
    logic [2:0] recall_num_r;
    logic alarm_oe_r, net_enable_r, irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // write decode
    wire wr_go = aw_full_r && w_full_r && !bvalid_r;
    wire wr_lo = w_strb_r[0];
    wire wr_ctrl = wr_go && aw_addr_r == PRA_OFS_CTRL;
    wire wr_mask = wr_go && aw_addr_r == PRA_OFS_IRQ_MASK;
    wire wr_ok = aw_addr_r == PRA_OFS_CTRL || aw_addr_r == PRA_OFS_IRQ_MASK ||
                 aw_addr_r == PRA_OFS_ALARM || aw_addr_r == PRA_OFS_PRESET ||
                 aw_addr_r == PRA_OFS_IRQ_STAT;
    wire alarm_clr = wr_ctrl && wr_lo && w_data_r[PRA_CTRL_ARST_BIT];
    wire view_nxt = (wr_ctrl && wr_lo) ? w_data_r[PRA_CTRL_VIEW_BIT] : view_open_r;
    wire view_rise = view_nxt && !view_open_r;

    // read decode
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire rd_stat = rd_go && s_axi_araddr == PRA_OFS_IRQ_STAT;
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            PRA_OFS_CTRL: begin
                rd_mux[PRA_CTRL_MODE_BIT] = remote_contact_port_r;
                rd_mux[PRA_CTRL_ALEN_BIT] = alarm_line_enable_r;
                rd_mux[PRA_CTRL_VIEW_BIT] = view_open_r;
            end
            PRA_OFS_ALARM: begin
                rd_mux[3:0] = alarm_lat_r;
                rd_mux[PRA_ALARM_SNAP_LSB +: 3] = snap_r;
            end
            PRA_OFS_PRESET: begin
                rd_mux[2:0] = recall_num_r;
                rd_mux[PRA_PRESET_BUSY_BIT] = rc_state_r == PRA_RC_WAIT;
            end
            PRA_OFS_IRQ_STAT: rd_mux[1:0] = irq_stat_r;
            PRA_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_r;
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= PRA_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? PRA_RESP_OKAY : PRA_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
            end
        end
    end

    // ready flops drop once the item is held, rise after the response
    logic awready_r, wready_r, arready_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
        end else begin
            awready_r <= !bvalid_r && !aw_full_r && !(s_axi_awvalid && awready_r);
            wready_r <= !bvalid_r && !w_full_r && !(s_axi_wvalid && wready_r);
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= PRA_RESP_OKAY;
        end else if (rd_go) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_ok ? PRA_RESP_OKAY : PRA_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end else begin
            arready_r <= !rvalid_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_contact_port_r <= PRA_CTRL_MODE_RST;
            alarm_line_enable_r <= PRA_CTRL_ALEN_RST;
            view_open_r <= 1'b0;
            irq_mask_r <= PRA_IRQ_MASK_RST;
        end else begin
            view_open_r <= view_nxt;
            if (wr_ctrl && wr_lo) begin
                remote_contact_port_r <= w_data_r[PRA_CTRL_MODE_BIT];
                alarm_line_enable_r <= w_data_r[PRA_CTRL_ALEN_BIT];
            end
            if (wr_mask && wr_lo) begin
                irq_mask_r <= w_data_r[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm latch: a present cause beats a reset in the same cycle
    wire pra_fault_t alarm_lat_nxt = (alarm_clr ? 4'h0 : alarm_lat_r) | fault_i;
    wire alarm_new = |(fault_i & ~alarm_lat_r);

    // reported code, most severe cause first
    wire [2:0] alarm_code = alarm_lat_r.fan_stop ? PRA_ALM_FAN :
                            alarm_lat_r.no_ref ? PRA_ALM_NO_REF :
                            alarm_lat_r.unlock ? PRA_ALM_UNLOCK :
                            alarm_lat_r.near_unlock ? PRA_ALM_NEAR : PRA_ALM_NONE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_lat_r <= 4'h0;
            snap_r <= PRA_ALM_NONE;
            alarm_oe_r <= 1'b0;
            net_enable_r <= 1'b0;
        end else begin
            alarm_lat_r <= alarm_lat_nxt;
            if (view_rise) begin
                snap_r <= alarm_code;
            end
            // open drain: pulling low is driving
            alarm_oe_r <= remote_contact_port_r && alarm_line_enable_r &&
                          (|alarm_lat_r);
            net_enable_r <= !remote_contact_port_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // contact input synchroniser and selection tracking
    wire sel_agree = sel_m2_r == sel_m3_r;
    wire [2:0] sel_code = ~sel_m3_r;
    wire recall_start = remote_contact_port_r && sel_agree &&
                        sel_code != sel_stable_r && sel_code != PRA_SEL_IDLE;
    wire dly_done = dly_cnt_r == 32'(RECALL_CYCLES_P - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_m1_r <= 3'h7;
            sel_m2_r <= 3'h7;
            sel_m3_r <= 3'h7;
            sel_stable_r <= PRA_SEL_IDLE;
        end else begin
            sel_m1_r <= contact_sel_n;
            sel_m2_r <= sel_m1_r;
            sel_m3_r <= sel_m2_r;
            if (sel_agree) begin
                sel_stable_r <= sel_code;
            end
        end
    end

    // recall delay; a newer combination restarts the wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_state_r <= PRA_RC_IDLE;
            dly_cnt_r <= 32'h0000_0000;
            pend_num_r <= PRA_SEL_IDLE;
            recall_stb_r <= 1'b0;
            recall_num_r <= PRA_SEL_IDLE;
        end else begin
            recall_stb_r <= 1'b0;
            if (recall_start) begin
                rc_state_r <= PRA_RC_WAIT;
                dly_cnt_r <= 32'h0000_0000;
                pend_num_r <= sel_code;
            end else begin
                case (rc_state_r)
                    PRA_RC_IDLE: dly_cnt_r <= 32'h0000_0000;
                    PRA_RC_WAIT: begin
                        if (!remote_contact_port_r) begin
                            rc_state_r <= PRA_RC_IDLE;
                        end else if (dly_done) begin
                            rc_state_r <= PRA_RC_IDLE;
                            recall_stb_r <= 1'b1;
                            recall_num_r <= pend_num_r;
                        end else begin
                            dly_cnt_r <= dly_cnt_r + 32'h0000_0001;
                        end
                    end
                    default: rc_state_r <= PRA_RC_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, cleared by reading; new events win over the clear
    wire [1:0] irq_ev = {alarm_new, recall_stb_r};
    wire [1:0] irq_stat_nxt = (rd_stat ? 2'h0 : irq_stat_r) | irq_ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 2'h0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign alarm_line_o = 1'b0;
    assign alarm_line_oe = alarm_oe_r;
    assign net_enable = net_enable_r;
    assign recall_stb = recall_stb_r;
    assign recall_num = recall_num_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [31:0] ast_wait_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || recall_start) begin
            ast_wait_r <= 32'h0000_0000;
        end else if (rc_state_r == PRA_RC_WAIT) begin
            ast_wait_r <= ast_wait_r + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_NET_BLOCKED: assert property (remote_contact_port_r |=> !net_enable)
        else $error("network left enabled in contact mode");
    AST_RECALL_NUM: assert property (recall_start |=> pend_num_r == ~$past(sel_m3_r))
        else $error("pending preset does not match pin levels");
    AST_RECALL_DELAY: assert property (recall_stb |-> ast_wait_r == RECALL_CYCLES_P)
        else $error("recall applied at the wrong delay");
    AST_NO_IDLE_RECALL: assert property (recall_stb |-> recall_num != PRA_SEL_IDLE)
        else $error("recall issued for idle combination");
    AST_ALARM_SETS: assert property (fault_i != 4'h0 |=> (alarm_lat_r & $past(fault_i)) == $past(fault_i))
        else $error("present fault not latched");
    AST_ALARM_HOLDS: assert property (!alarm_clr |=> (alarm_lat_r & $past(alarm_lat_r)) == $past(alarm_lat_r))
        else $error("latched alarm lost without reset");
    AST_LINE_LOW: assert property ((|alarm_lat_r && remote_contact_port_r && alarm_line_enable_r) |=> alarm_line_oe && !alarm_line_o)
        else $error("alarm line not pulled low");
    AST_LINE_OFF: assert property (!alarm_line_enable_r |=> !alarm_line_oe)
        else $error("alarm line driven while disabled");
    AST_FAN_CODE: assert property (alarm_lat_r.fan_stop |-> alarm_code == PRA_ALM_FAN)
        else $error("fan fault not reported first");
    AST_SNAP_HELD: assert property (!view_rise |=> $stable(snap_r))
        else $error("status snapshot changed while view open");
    COV_RECALL: cover property (recall_start ##1 (rc_state_r == PRA_RC_WAIT));
    COV_ALARM_LINE: cover property (alarm_new ##[1:3] alarm_line_oe);
    COV_RESET_REFIRE: cover property (alarm_clr && fault_i != 4'h0);
    COV_IRQ: cover property (rd_stat ##1 !irq);
endmodule

// ---- verification/pra_contact_model.sv ----
/*
 * contact-side equipment model: drives the three selection levels, reads the alarm pin.
 * assumes the bench calls drive() and that the alarm pin has an outside pull-up.
 */
`timescale 1ns/1ps

module pra_contact_model (
    // clock
    input wire logic aclk,
    // contact pins
    output logic [2:0] contact_sel_n,
    input wire logic alarm_line_o,
    input wire logic alarm_line_oe,
    output logic alarm_wire
);
    initial contact_sel_n = 3'h7;

    // open drain pin, pulled high when released
    assign alarm_wire = alarm_line_oe ? alarm_line_o : 1'b1;

    // low level means one; level held until the next call
    task automatic drive(input logic [2:0] code);
        @(posedge aclk);
        contact_sel_n <= ~code;
    endtask
endmodule

// ---- verification/test_preset_recall_alarm_port.sv ----
/*
 * self-checking bench for the preset recall and alarm port, with a queue model.
 * assumes the contact model file is compiled before this one.
 */
`timescale 1ns/1ps

module test_preset_recall_alarm_port;
    import pra_pkg::*;
    localparam int RC = 20;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, alo, aloe, awire, net_en, stb, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [2:0] sel_n, num;
    logic [3:0] f, wstrb;
    pra_fault_t fault;
    int n_errors, compares, c;
    int exp_q[$];

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    pra_port #(.RECALL_CYCLES_P(RC)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .contact_sel_n(sel_n), .alarm_line_o(alo), .alarm_line_oe(aloe),
        .fault_i(fault), .net_enable(net_en), .recall_stb(stb), .recall_num(num), .irq(irq)
    );

    pra_contact_model cm (
        .aclk(aclk), .contact_sel_n(sel_n), .alarm_line_o(alo),
        .alarm_line_oe(aloe), .alarm_wire(awire)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dat;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
        end while (rvalid !== 1'b1);
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wrk(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] resp;
        wr(a, dat, resp);
        chk("bresp", PRA_RESP_OKAY, 32'(resp));
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dat;
        logic [1:0] resp;
        rd(a, dat, resp);
        chk("rresp", PRA_RESP_OKAY, 32'(resp));
        chk(what, exp, dat);
    endtask

    // watches recalls over a span and returns the cycle of the first; each must match the head of the model queue
    task automatic wait_stb(input int span, output int first);
        first = -1;
        for (int i = 1; i <= span; i++) begin
            @(posedge aclk);
            if (stb === 1'b1) begin
                if (first < 0) first = i;
                if (exp_q.size() > 0) begin
                    chk("recall_num", exp_q.pop_front(), 32'(num));
                end else begin
                    chk("unexpected recall", 0, 1);
                end
            end
        end
        chk("missed recalls", 0, exp_q.size());
    endtask

    // model of the alarm register: snapshot code above the latched faults
    function automatic logic [31:0] alarm_word(input logic [3:0] lat);
        logic [2:0] code;
        code = lat[3] ? PRA_ALM_FAN : lat[2] ? PRA_ALM_NO_REF :
               lat[1] ? PRA_ALM_UNLOCK : lat[0] ? PRA_ALM_NEAR : PRA_ALM_NONE;
        return {25'h0, code, lat};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        fault = '0;
        n_errors = 0;
        compares = 0;
        void'($urandom(2212));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("net_enable", 1, 32'(net_en));
        rchk("ctrl reset", PRA_OFS_CTRL, 32'h0);
        rchk("irq mask reset", PRA_OFS_IRQ_MASK, 32'h0);
        rd(8'h20, d, r);
        chk("unmapped rdata", 0, d);
        chk("unmapped rresp", PRA_RESP_SLVERR, 32'(r));
        wr(8'h20, 32'hFFFFFFFF, r);
        chk("unmapped bresp", PRA_RESP_SLVERR, 32'(r));
        cm.drive(3'h2);
        wait_stb(3 * RC, c);
        cm.drive(3'h0);
        wrk(PRA_OFS_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        chk("net_enable", 0, 32'(net_en));
        for (int p = 1; p <= 7; p++) begin
            cm.drive(3'(p));
            exp_q.push_back(p);
            wait_stb(3 * RC, c);
            chk("recall delay", 1, 32'(c >= RC + 2 && c <= RC + 7));
            cm.drive(3'h0);
            wait_stb(RC + 8, c);
        end
        rchk("preset", PRA_OFS_PRESET, 32'h7);
        rchk("irq stat", PRA_OFS_IRQ_STAT, 32'h1);
        rchk("irq stat cleared", PRA_OFS_IRQ_STAT, 32'h0);
        cm.drive(3'h3);
        repeat (5) @(posedge aclk);
        f = 4'($urandom_range(7, 4));
        cm.drive(f[2:0]);
        exp_q.push_back(f);
        wait_stb(3 * RC, c);
        cm.drive(3'h0);
        wrk(PRA_OFS_IRQ_MASK, 32'h2);
        rchk("irq mask", PRA_OFS_IRQ_MASK, 32'h2);
        wrk(PRA_OFS_CTRL, 32'h3);
        wstrb <= {3'($urandom()), 1'b0};
        wrk(PRA_OFS_CTRL, 32'h0);
        wstrb <= 4'hF;
        rchk("ctrl lane 0 only", PRA_OFS_CTRL, 32'h3);
        rchk("irq stat", PRA_OFS_IRQ_STAT, 32'h1);
        f = 4'($urandom_range(15, 1));
        @(posedge aclk);
        fault <= pra_fault_t'(f);
        repeat (4) @(posedge aclk);
        chk("alarm wire", 0, 32'(awire));
        chk("irq", 1, 32'(irq));
        fault <= '0;
        repeat (4) @(posedge aclk);
        chk("alarm wire held", 0, 32'(awire));
        wrk(PRA_OFS_CTRL, 32'hB);
        rchk("alarm", PRA_OFS_ALARM, alarm_word(f));
        rchk("irq stat", PRA_OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq", 0, 32'(irq));
        fault <= pra_fault_t'(4'h8);
        repeat (4) @(posedge aclk);
        rchk("alarm snapshot", PRA_OFS_ALARM, alarm_word(f) | 32'h8);
        wrk(PRA_OFS_CTRL, 32'h7);
        rd(PRA_OFS_ALARM, d, r);
        chk("alarm after reset", 32'h8, d & 32'hF);
        fault <= '0;
        wrk(PRA_OFS_CTRL, 32'h7);
        wrk(PRA_OFS_CTRL, 32'hB);
        rchk("alarm cleared", PRA_OFS_ALARM, 32'h0);
        chk("alarm wire idle", 1, 32'(awire));
        for (int k = 0; k < 4; k++) begin
            fault <= pra_fault_t'(4'h1 << k);
            wrk(PRA_OFS_CTRL, 32'h7);
            wrk(PRA_OFS_CTRL, 32'hB);
            rchk("alarm code", PRA_OFS_ALARM, alarm_word(4'h1 << k));
        end
        wrk(PRA_OFS_CTRL, 32'h5);
        repeat (4) @(posedge aclk);
        chk("alarm wire disabled", 1, 32'(awire));
        wrk(PRA_OFS_CTRL, 32'h3);
        repeat (4) @(posedge aclk);
        chk("alarm wire enabled", 0, 32'(awire));
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("net_enable after reset", 1, 32'(net_en));
        chk("alarm wire after reset", 1, 32'(awire));
        chk("irq after reset", 0, 32'(irq));
        rchk("ctrl after reset", PRA_OFS_CTRL, 32'h0);
        end_sim();
    end
endmodule
